// File: rtl/lpd_core.sv
// LPDDR2 die command decoder, bank state, burst engines and small data array.
// Assumes sys_clk_in oversamples CK and DQS by at least 8x; all pins are asynchronous to it.
// Notes on behaviour
// - training reads drive 1,0,1,0 (A) or 0,0,1,1 (B) over four bit times
// - activate is select low, CA0 low, CA1 high at CK rise
// - activate takes bank from three bank bits and row R0..
// - column command is CA0 high, CA1 low; CA2 high read, low write
// - bursts 4, 8, 16 stay in aligned segment; order from start and type
// - C0 zero, C1 CA5 rise, C2 CA6 rise, C3 CA1 fall
// - sequential wraps, interleave XORs for 4/8, 16 sequential, no-wrap linear for 4 only
// - reads drive DQS low preamble, first bit on first DQS rise, RL later
// - back-to-back reads every 2, 4 or 8 clocks run gapless
// - reads interrupted only by reads on even clocks; effective length doubles spacing
// - back-to-back writes every 2, 4 or 8 clocks run gapless
// - writes interrupted only by writes on even clocks, any bank
// - one mask per byte; high mask keeps old byte, zero latency
// - precharge is CA0,CA1 high, CA2 low, CA3 high; one or all banks
// - burst length code 010 is 4, 011 is 8, 100 is 16
// - burst type 0 sequential, 1 interleaved
// - latency code 1 gives RL3/WL1, up to RL8/WL4
`timescale 1ns/1ps
module lpd_core
  import lpd_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              ck_in,
  input  wire logic              cs_n_in,
  input  wire logic [CA_W-1:0]   ca_in,
  input  wire logic [DQ_W-1:0]   dq_in,
  output logic      [DQ_W-1:0]   dq_out,
  output logic                   dq_oe_out,
  input  wire logic              dqs_in,
  output logic                   dqs_out,
  output logic                   dqs_oe_out,
  input  wire logic [DM_W-1:0]   dm_in,
  input  wire logic [7:0]        burst_feature_register_in,
  input  wire logic [7:0]        latency_feature_register_in,
  input  wire logic              pattern_req_in,
  input  wire logic              pattern_sel_b_in,
  output logic      [BANKS-1:0]  bank_open_out,
  output logic                   wbuf_ready_out
);
  localparam int PIN_W = 2 + CA_W + 1 + DM_W + DQ_W;

  // Pin and configuration synchronisers
  logic [PIN_W-1:0] pin_meta_q;
  logic [PIN_W-1:0] pin_sync_q;
  logic [15:0]      cfg_meta_q;
  logic [15:0]      cfg_sync_q;
  logic             ck_d_q;
  logic             dqs_d_q;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      cfg_meta_q <= {BURST_FEATURE_RST, LATENCY_FEATURE_RST};
      cfg_sync_q <= {BURST_FEATURE_RST, LATENCY_FEATURE_RST};
      ck_d_q     <= 1'b0;
      dqs_d_q    <= 1'b0;
    end else begin
      pin_meta_q <= {ck_in, cs_n_in, ca_in, dqs_in, dm_in, dq_in};
      pin_sync_q <= pin_meta_q;
      cfg_meta_q <= {burst_feature_register_in, latency_feature_register_in};
      cfg_sync_q <= cfg_meta_q;
      ck_d_q     <= pin_sync_q[PIN_W-1];
      dqs_d_q    <= pin_sync_q[DQ_W+DM_W];
    end
  end

  wire logic            ck_s;
  wire logic            cs_n_s;
  wire logic [CA_W-1:0] ca_s;
  wire logic            dqs_s;
  wire logic [DM_W-1:0] dm_s;
  wire logic [DQ_W-1:0] dq_s;
  assign {ck_s, cs_n_s, ca_s, dqs_s, dm_s, dq_s} = pin_sync_q;

  wire ck_rise  = ck_s && !ck_d_q;
  wire ck_fall  = !ck_s && ck_d_q;
  wire ck_edge  = ck_rise || ck_fall;
  wire dqs_edge = dqs_s ^ dqs_d_q;
  wire dqs_rise = dqs_s && !dqs_d_q;

  // Feature settings
  wire [7:0] burst_cfg   = cfg_sync_q[15:8];
  wire lpd_len_e cfg_len = len_of(burst_cfg[BF_BL_LSB +: 3]);
  wire       cfg_intl    = burst_cfg[BF_BT_BIT];
  wire       cfg_nowrap  = burst_cfg[BF_WC_BIT];
  wire [3:0] rl = rl_of(cfg_sync_q[3:0]);
  wire [3:0] wl = wl_of(cfg_sync_q[3:0]);

  // Rising half of the command is held until the falling half arrives
  logic [CA_W-1:0] ca_r_q;
  logic            cs_n_r_q;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ca_r_q   <= '0;
      cs_n_r_q <= 1'b1;
    end else if (ck_rise) begin
      ca_r_q   <= ca_s;
      cs_n_r_q <= cs_n_s;
    end
  end

  wire sel = ck_fall && !cs_n_r_q;
  wire is_act = sel && !ca_r_q[CA_OP0] && ca_r_q[CA_OP1];
  wire is_col = sel && ca_r_q[CA_OP0] && !ca_r_q[CA_OP1];
  wire is_rd  = ca_r_q[CA_OP2];
  wire is_pre = sel && ca_r_q[CA_OP0] && ca_r_q[CA_OP1] && !ca_r_q[CA_OP2] && ca_r_q[CA_OP3];
  wire pre_all = ca_r_q[CA_ALLBK];
  wire [BANK_W-1:0] cmd_bank = ca_r_q[CA_BA_LSB +: BANK_W];
  wire [ROW_W-1:0] act_row = {ca_r_q[CA_ROW_HI +: ROW_W-CA_W], ca_s};
  wire [COL_W-1:0] col_start = {ca_s[CA_F_C3 +: COL_W-3], ca_r_q[CA_C2], ca_r_q[CA_C1], 1'b0};

  // Bank state
  logic [BANKS-1:0] bank_open_q;
  logic [ROW_W-1:0] open_row_q [BANKS];

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bank_open_q <= '0;
      for (int b = 0; b < BANKS; b++) open_row_q[b] <= '0;
    end else if (is_act) begin
      bank_open_q[cmd_bank] <= 1'b1;
      open_row_q[cmd_bank]  <= act_row;
    end else if (is_pre) begin
      if (pre_all) bank_open_q <= '0;
      else bank_open_q[cmd_bank] <= 1'b0;
    end
  end

  // Column commands and training reads enter a CK-rise delay line
  lpd_cmd_s new_q;
  lpd_cmd_s pipe_q [PIPE_D];
  lpd_cmd_s stage [PIPE_D];
  logic     train_pend_q;

  wire col_ok    = is_col && bank_open_q[cmd_bank];
  wire train_ins = ck_fall && train_pend_q && !col_ok;

  lpd_cmd_s col_entry;
  always_comb begin
    col_entry.valid  = 1'b1;
    col_entry.kind   = is_rd ? KIND_READ : KIND_WRITE;
    col_entry.pat_b  = 1'b0;
    col_entry.bank   = cmd_bank;
    col_entry.row_lo = open_row_q[cmd_bank][ROW_KEEP-1:0];
    col_entry.col    = col_start;
  end

  lpd_cmd_s train_entry;
  always_comb begin
    train_entry       = '0;
    train_entry.valid = 1'b1;
    train_entry.kind  = KIND_TRAIN;
    train_entry.pat_b = pattern_sel_b_in;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      new_q        <= '0;
      train_pend_q <= 1'b0;
      for (int i = 0; i < PIPE_D; i++) pipe_q[i] <= '0;
    end else begin
      // A request in the same cycle as insertion stays pending
      train_pend_q <= pattern_req_in || (train_pend_q && !train_ins);
      if (col_ok) new_q <= col_entry;
      else if (train_ins) new_q <= train_entry;
      else if (ck_rise) new_q <= '0;
      if (ck_rise) begin
        pipe_q[1] <= new_q;
        for (int i = 2; i < PIPE_D; i++) pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  assign stage[0] = new_q;
  for (genvar g = 1; g < PIPE_D; g++) begin : g_stage
    assign stage[g] = pipe_q[g];
  end

  wire [2:0] rd_idx  = 3'(rl - 4'h1);
  wire [2:0] pre_idx = 3'(rl - 4'h2);
  wire [2:0] wr_idx  = 3'(wl - 4'h1);
  wire lpd_cmd_s rd_tap  = stage[rd_idx];
  wire lpd_cmd_s pre_tap = stage[pre_idx];
  wire lpd_cmd_s wr_tap  = stage[wr_idx];

  // data RL rises after the command, preamble one clock earlier
  wire rd_start = ck_rise && rd_tap.valid && rd_tap.kind != KIND_WRITE;
  wire rd_pre   = ck_rise && pre_tap.valid && pre_tap.kind != KIND_WRITE;
  wire wr_start = ck_rise && wr_tap.valid && wr_tap.kind == KIND_WRITE;

  // Read engine
  lpd_rd_state_e rd_state_q;
  lpd_cmd_s      rd_cmd_q;
  lpd_len_e      rd_len_q;
  logic [3:0]    rd_beat_q;

  // a new read replaces the rest of the current one
  wire rd_cont = ck_edge && rd_state_q == RD_DATA && !rd_start;
  wire rd_emit = rd_start || rd_cont;
  wire lpd_cmd_s emit_cmd  = rd_start ? rd_tap : rd_cmd_q;
  wire lpd_len_e start_len = (rd_tap.kind == KIND_TRAIN) ? LEN4 : cfg_len;
  wire lpd_len_e emit_len  = rd_start ? start_len : rd_len_q;
  wire [3:0]     emit_beat = rd_start ? 4'h0 : rd_beat_q;
  wire           emit_last = ({1'b0, emit_beat} == 5'(beats_of(emit_len) - 5'h01));

  logic [COL_W-1:0] rd_col;
  // beat order within the aligned segment
  lpd_burst_order u_rd_order (
    .start_col_in  (emit_cmd.col),
    .beat_in       (emit_beat),
    .len_in        (emit_len),
    .interleave_in (cfg_intl),
    .nowrap_in     (cfg_nowrap),
    .col_out       (rd_col)
  );

  logic [DQ_W-1:0] mem_q [2**MEM_IDX_W];
  wire [MEM_IDX_W-1:0] rd_idx_mem = {emit_cmd.bank, emit_cmd.row_lo, rd_col[COL_KEEP-1:0]};
  // training sequence on every DQ bit
  wire [3:0]       train_seq = emit_cmd.pat_b ? TRAIN_B_SEQ : TRAIN_A_SEQ;
  wire [DQ_W-1:0]  emit_data = (emit_cmd.kind == KIND_TRAIN) ? {DQ_W{train_seq[emit_beat[1:0]]}}
                                                               : mem_q[rd_idx_mem];

  logic [DQ_W-1:0] dq_q;
  logic            dq_oe_q;
  logic            dqs_q;
  logic            dqs_oe_q;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_state_q <= RD_IDLE;
      rd_cmd_q   <= '0;
      rd_len_q   <= LEN4;
      rd_beat_q  <= '0;
      dq_q       <= '0;
      dq_oe_q    <= 1'b0;
      dqs_q      <= 1'b0;
      dqs_oe_q   <= 1'b0;
    end else if (rd_emit) begin
      // data edge-aligned, DQS high on rise beats
      // a read landing after the last beat keeps DQS running
      rd_state_q <= emit_last ? RD_IDLE : RD_DATA;
      rd_cmd_q   <= emit_cmd;
      rd_len_q   <= emit_len;
      rd_beat_q  <= emit_beat + 4'h1;
      dq_q       <= emit_data;
      dq_oe_q    <= 1'b1;
      dqs_q      <= ck_rise;
      dqs_oe_q   <= 1'b1;
    end else if (ck_edge) begin
      // preamble holds DQS low before data
      if (rd_pre || rd_state_q == RD_PRE) begin
        rd_state_q <= RD_PRE;
        dqs_oe_q   <= 1'b1;
      end else begin
        dqs_oe_q   <= 1'b0;
      end
      dq_oe_q <= 1'b0;
      dqs_q   <= 1'b0;
    end
  end

  assign dq_out     = dq_q;
  assign dq_oe_out  = dq_oe_q;
  assign dqs_out    = dqs_q;
  assign dqs_oe_out = dqs_oe_q;

  // Write engine: beats taken on DQS edges, first one on a rising edge
  logic       wr_active_q;
  lpd_cmd_s   wr_cmd_q;
  lpd_len_e   wr_len_q;
  logic [3:0] wr_beat_q;

  wire wr_take = wr_active_q && !wr_start && dqs_edge && (wr_beat_q != 4'h0 || dqs_rise);
  wire wr_last = ({1'b0, wr_beat_q} == 5'(beats_of(wr_len_q) - 5'h01));

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_active_q <= 1'b0;
      wr_cmd_q    <= '0;
      wr_len_q    <= LEN4;
      wr_beat_q   <= '0;
    end else if (wr_start) begin
      // a new write restarts the beat count
      wr_active_q <= 1'b1;
      wr_cmd_q    <= wr_tap;
      wr_len_q    <= cfg_len;
      wr_beat_q   <= '0;
    end else if (wr_take) begin
      wr_beat_q <= wr_beat_q + 4'h1;
      if (wr_last) wr_active_q <= 1'b0;
    end
  end

  logic [COL_W-1:0] wr_col;
  lpd_burst_order u_wr_order (
    .start_col_in  (wr_cmd_q.col),
    .beat_in       (wr_beat_q),
    .len_in        (wr_len_q),
    .interleave_in (cfg_intl),
    .nowrap_in     (cfg_nowrap),
    .col_out       (wr_col)
  );

  // mask sampled with its own beat
  lpd_wword_s wb_in;
  assign wb_in.idx  = {wr_cmd_q.bank, wr_cmd_q.row_lo, wr_col[COL_KEEP-1:0]};
  assign wb_in.data = dq_s;
  assign wb_in.mask = dm_s;

  lpd_wword_s wb_out;
  logic       wb_out_valid;
  // Array port is shared; a read beat fetch stalls the drain
  wire        wb_drain = wb_out_valid && !rd_emit;

  lpd_fifo #(
    .WIDTH ($bits(lpd_wword_s)),
    .DEPTH (WBUF_D)
  ) u_wbuf (
    .clk_in        (sys_clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (wr_take),
    .in_ready_out  (wbuf_ready_out),
    .in_data_in    (wb_in),
    .out_valid_out (wb_out_valid),
    .out_ready_in  (!rd_emit),
    .out_data_out  (wb_out)
  );

  always_ff @(posedge sys_clk_in) begin
    if (wb_drain) begin
      for (int b = 0; b < DM_W; b++) begin
        if (!wb_out.mask[b]) mem_q[wb_out.idx][b*8 +: 8] <= wb_out.data[b*8 +: 8];
      end
    end
  end

  assign bank_open_out = bank_open_q;
endmodule

// File: rtl/lpd_pkg.sv
// Shared constants, types and decode functions for the LPDDR2 command and burst core.
// Assumes one system clock that oversamples the memory clock CK by a wide margin.
package lpd_pkg;
  localparam int CA_W      = 10;
  localparam int DQ_W      = 32;
  localparam int DM_W      = 4;
  localparam int BANKS     = 8;
  localparam int BANK_W    = 3;
  localparam int ROW_W     = 14;
  localparam int COL_W     = 9;
  localparam int ROW_KEEP  = 2;
  localparam int COL_KEEP  = 5;
  localparam int MEM_IDX_W = BANK_W + ROW_KEEP + COL_KEEP;
  localparam int PIPE_D    = 8;
  localparam int WBUF_D    = 4;
  // Command bus bit positions
  localparam int CA_OP0    = 0;
  localparam int CA_OP1    = 1;
  localparam int CA_OP2    = 2;
  localparam int CA_OP3    = 3;
  localparam int CA_ALLBK  = 4;
  localparam int CA_C1     = 5;
  localparam int CA_C2     = 6;
  localparam int CA_BA_LSB = 7;
  localparam int CA_ROW_HI = 2;
  localparam int CA_F_C3   = 1;
  // Feature register fields and reset values
  localparam int BF_BL_LSB = 0;
  localparam int BF_BT_BIT = 3;
  localparam int BF_WC_BIT = 4;
  localparam logic [7:0] BURST_FEATURE_RST   = 8'h22;
  localparam logic [7:0] LATENCY_FEATURE_RST = 8'h01;
  localparam logic [2:0] BL_CODE_4  = 3'h2;
  localparam logic [2:0] BL_CODE_8  = 3'h3;
  localparam logic [2:0] BL_CODE_16 = 3'h4;
  // Training sequences, bit t drives at bit time t
  localparam logic [3:0] TRAIN_A_SEQ = 4'h5;
  localparam logic [3:0] TRAIN_B_SEQ = 4'hC;

  typedef enum logic [1:0] {KIND_READ, KIND_WRITE, KIND_TRAIN} lpd_kind_e;
  typedef enum logic [1:0] {LEN4, LEN8, LEN16} lpd_len_e;
  typedef enum logic [1:0] {RD_IDLE, RD_PRE, RD_DATA} lpd_rd_state_e;

  typedef struct packed {
    logic                valid;
    lpd_kind_e           kind;
    logic                pat_b;
    logic [BANK_W-1:0]   bank;
    logic [ROW_KEEP-1:0] row_lo;
    logic [COL_W-1:0]    col;
  } lpd_cmd_s;

  typedef struct packed {
    logic [MEM_IDX_W-1:0] idx;
    logic [DQ_W-1:0]      data;
    logic [DM_W-1:0]      mask;
  } lpd_wword_s;

  function automatic lpd_len_e len_of(input logic [2:0] code);
    case (code)
      BL_CODE_8:  len_of = LEN8;
      BL_CODE_16: len_of = LEN16;
      default:    len_of = LEN4;
    endcase
  endfunction

  function automatic logic [4:0] beats_of(input lpd_len_e len);
    case (len)
      LEN8:    beats_of = 5'h08;
      LEN16:   beats_of = 5'h10;
      default: beats_of = 5'h04;
    endcase
  endfunction

  function automatic logic [3:0] rl_of(input logic [3:0] code);
    case (code)
      4'h2:    rl_of = 4'h4;
      4'h3:    rl_of = 4'h5;
      4'h4:    rl_of = 4'h6;
      4'h5:    rl_of = 4'h7;
      4'h6:    rl_of = 4'h8;
      default: rl_of = 4'h3;
    endcase
  endfunction

  function automatic logic [3:0] wl_of(input logic [3:0] code);
    case (code)
      4'h2, 4'h3: wl_of = 4'h2;
      4'h4:       wl_of = 4'h3;
      4'h5, 4'h6: wl_of = 4'h4;
      default:    wl_of = 4'h1;
    endcase
  endfunction
endpackage

// File: rtl/lpd_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; pointers carry one extra wrap bit.
`timescale 1ns/1ps
module lpd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_q [DEPTH];
  logic [AW:0]      wptr_q;
  logic [AW:0]      rptr_q;
  wire              full  = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
  wire              empty = (wptr_q == rptr_q);
  wire              push  = in_valid_in && !full;
  wire              pop   = out_ready_in && !empty;

  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = store_q[rptr_q[AW-1:0]];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      if (push) wptr_q <= wptr_q + 1'b1;
      if (pop) rptr_q <= rptr_q + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) store_q[wptr_q[AW-1:0]] <= in_data_in;
  end
endmodule

// File: rtl/lpd_burst_order.sv
// Column address of one beat within a burst, from start column and beat number.
// Purely combinational; the caller supplies the latched burst length and the live type and wrap settings.
`timescale 1ns/1ps
module lpd_burst_order
  import lpd_pkg::*;
(
  input  wire logic [COL_W-1:0] start_col_in,
  input  wire logic [3:0]       beat_in,
  input  wire lpd_len_e         len_in,
  input  wire logic             interleave_in,
  input  wire logic             nowrap_in,
  output logic      [COL_W-1:0] col_out
);
  wire [3:0] seg_mask = (len_in == LEN4) ? 4'h3 : (len_in == LEN8) ? 4'h7 : 4'hF;
  wire [3:0] seq_low  = start_col_in[3:0] + beat_in;
  wire [3:0] int_low  = start_col_in[3:0] ^ beat_in;
  // Interleave only for 4 and 8; 16 falls back to sequential
  wire [3:0] pick_low = (interleave_in && len_in != LEN16) ? int_low : seq_low;
  wire [3:0] wrap_low = (start_col_in[3:0] & ~seg_mask) | (pick_low & seg_mask);
  wire [COL_W-1:0] linear = start_col_in + {{(COL_W-4){1'b0}}, beat_in};

  // no-wrap runs linearly, only for length 4
  assign col_out = (nowrap_in && len_in == LEN4) ? linear : {start_col_in[COL_W-1:4], wrap_low};
endmodule

// File: verification/lpd_core_chk.sv
// Checker for the core's memory-side outputs.
// Assumes sys_clk_in oversamples ck_in by at least 8x.
`timescale 1ns/1ps
module lpd_core_chk
  import lpd_pkg::*;
(
  input  wire logic             sys_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ck_in,
  input  wire logic [DQ_W-1:0]  dq_out,
  input  wire logic             dq_oe_out,
  input  wire logic             dqs_out,
  input  wire logic             dqs_oe_out,
  input  wire logic [BANKS-1:0] bank_open_out
);
  logic       ck_prev_q;
  logic [3:0] ck_still_q;
  wire        ck_quiet = ck_still_q >= 4'h8;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Outputs may only move in the few cycles after a CK edge
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ck_prev_q  <= 1'b0;
      ck_still_q <= 4'h0;
    end else begin
      ck_prev_q  <= ck_in;
      ck_still_q <= (ck_in != ck_prev_q) ? 4'h0 : ck_still_q + {3'h0, ck_still_q != 4'hF};
    end
  end
  a_strobe_with_data: assert property (dq_oe_out |-> dqs_oe_out)
    else $error("data driven without strobe");
  a_preamble_low: assert property ($rose(dqs_oe_out) |-> !dqs_out)
    else $error("strobe not low when first driven");
  a_preamble_first: assert property ($rose(dq_oe_out) |-> $past(dqs_oe_out) && !$past(dqs_out))
    else $error("data without low preamble");
  a_first_bit_rise: assert property ($rose(dq_oe_out) |-> dqs_out)
    else $error("first beat not on strobe rise");
  a_beat_on_edge: assert property (dq_oe_out && $past(dq_oe_out) && $changed(dq_out) |-> $changed(dqs_out))
    else $error("beat changed without strobe edge");
  a_beat_stands: assert property (ck_quiet |-> $stable(dqs_out) && $stable(dq_oe_out) && $stable(dqs_oe_out) &&
                                   (!dq_oe_out || $stable(dq_out)))
    else $error("output moved without clock edge");
  a_bank_quiet: assert property (ck_quiet |-> $stable(bank_open_out))
    else $error("bank state moved without clock edge");
  a_release_together: assert property ($fell(dq_oe_out) |-> $fell(dqs_oe_out) && !$past(dqs_out))
    else $error("burst end not on falling strobe");
endmodule
bind lpd_core lpd_core_chk i_chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .ck_in(ck_in), .dq_out(dq_out),
  .dq_oe_out(dq_oe_out), .dqs_out(dqs_out), .dqs_oe_out(dqs_oe_out), .bank_open_out(bank_open_out));

// File: verification/lpd_ctl_model.sv
// Memory controller model: CK, select, command bus, write data, mask and strobe.
// Assumes one caller at a time, entering tasks just after a sys clock edge.
`timescale 1ns/1ps
module lpd_ctl_model
  import lpd_pkg::*;
(
  input  wire logic            sys_clk_in,
  output logic                 ck_out,
  output logic                 cs_n_out,
  output logic [CA_W-1:0]      ca_out,
  output logic [DQ_W-1:0]      dq_out,
  output logic                 dqs_out,
  output logic [DM_W-1:0]      dm_out,
  input  wire logic [DQ_W-1:0] rd_dq_in,
  input  wire logic            rd_dq_oe_in,
  input  wire logic            rd_dqs_in
);
  logic [DQ_W-1:0] rd_q[$];
  logic            dqs_seen;
  initial begin
    ck_out = 1'b0;
    cs_n_out = 1'b1;
    ca_out = '0;
    dq_out = '0;
    dqs_out = 1'b0;
    dm_out = '0;
  end
  // Half a CK period; pins set well away from CK and DQS edges
  task automatic half(input logic [CA_W-1:0] a, input logic c, input logic [DQ_W-1:0] d,
                      input logic [DM_W-1:0] m, input logic s);
    ca_out   <= a;
    cs_n_out <= c;
    dq_out   <= d;
    dm_out   <= m;
    repeat (8) @(posedge sys_clk_in);
    ck_out <= ~ck_out;
    repeat (4) @(posedge sys_clk_in);
    if (s) dqs_out <= ~dqs_out;
    repeat (4) @(posedge sys_clk_in);
  endtask
  // Released data and mask lines show the inverse of their last value
  task automatic cmd(input logic [CA_W-1:0] r, input logic [CA_W-1:0] f, input logic c);
    half(r, c, ~dq_out, ~dm_out, 1'b0);
    half(f, c, ~dq_out, ~dm_out, 1'b0);
  endtask
  task automatic idle(input int n);
    repeat (n) half(~ca_out, 1'b1, ~dq_out, ~dm_out, 1'b0);
  endtask
  always @(posedge sys_clk_in) begin
    dqs_seen <= rd_dqs_in;
    if (rd_dq_oe_in && rd_dqs_in !== dqs_seen) rd_q.push_back(rd_dq_in);
  end
endmodule

// File: verification/lpd_core_tb.sv
// Self-checking bench for the core, driven through the controller model.
// Assumes a 200 MHz system clock and CK at 160 ns.
`timescale 1ns/1ps
module lpd_core_tb
  import lpd_pkg::*;
;
  logic             sys_clk_in;
  logic             rst_n_in;
  logic [7:0]       bf;
  logic [7:0]       lf;
  logic             preq;
  logic             psel;
  logic             ck, cs_n, dq_oe, dqs_w, dqs_r, dqs_oe, wrdy;
  logic [CA_W-1:0]  ca;
  logic [DQ_W-1:0]  dq_w, dq_r;
  logic [DM_W-1:0]  dm;
  logic [BANKS-1:0] bopen;
  int               err_total = 0;
  int               tests_run = 0;
  wire [DQ_W-1:0]   dq_wire;
  wire              dqs_wire;
  assign dq_wire  = dq_oe ? dq_r : dq_w;
  assign dqs_wire = dqs_oe ? dqs_r : dqs_w;
  always #2.5 sys_clk_in = ~sys_clk_in;
  lpd_ctl_model i_ctl (.sys_clk_in(sys_clk_in), .ck_out(ck), .cs_n_out(cs_n), .ca_out(ca), .dq_out(dq_w),
    .dqs_out(dqs_w), .dm_out(dm), .rd_dq_in(dq_wire), .rd_dq_oe_in(dq_oe), .rd_dqs_in(dqs_wire));
  lpd_core i_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .ck_in(ck), .cs_n_in(cs_n), .ca_in(ca),
    .dq_in(dq_wire), .dq_out(dq_r), .dq_oe_out(dq_oe), .dqs_in(dqs_wire), .dqs_out(dqs_r), .dqs_oe_out(dqs_oe),
    .dm_in(dm), .burst_feature_register_in(bf), .latency_feature_register_in(lf), .pattern_req_in(preq),
    .pattern_sel_b_in(psel), .bank_open_out(bopen), .wbuf_ready_out(wrdy));
  task automatic chk_word(input logic [DQ_W-1:0] got, input logic [DQ_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic [BANKS-1:0] got, input logic [BANKS-1:0] exp);
    chk_word({24'h0, got}, {24'h0, exp});
  endtask
  function automatic logic [CA_W-1:0] ca_col(input logic [2:0] b, input logic [8:0] c, input logic r);
    return {b, c[2], c[1], 2'b00, r, 2'b01};
  endfunction
  task automatic rd(input logic [2:0] b, input logic [8:0] c);
    i_ctl.cmd(ca_col(b, c, 1'b1), {3'h0, c[8:3], 1'b0}, 1'b0);
  endtask
  task automatic wr(input logic [2:0] b, input logic [8:0] c, input int n, input logic [DQ_W-1:0] base,
                    input logic [DM_W-1:0] m1);
    i_ctl.cmd(ca_col(b, c, 1'b0), {3'h0, c[8:3], 1'b0}, 1'b0);
    for (int k = 0; k < n; k++) i_ctl.half(~ca, 1'b1, base + DQ_W'(k), k == 1 ? m1 : 4'h0, 1'b1);
    i_ctl.idle(6);
  endtask
  // Beat k must hold the word written at column ord[k]
  task automatic expect_seq(input logic [DQ_W-1:0] base, input logic [63:0] ord, input int n);
    chk_word(DQ_W'(i_ctl.rd_q.size()), DQ_W'(n));
    for (int k = 0; k < n; k++) chk_word(i_ctl.rd_q[k], base + DQ_W'(ord[4*k +: 4]));
    i_ctl.rd_q.delete();
  endtask
  task automatic t_banks();
    i_ctl.cmd({3'h3, 7'h02}, 10'h000, 1'b0);
    i_ctl.idle(4);
    i_ctl.cmd({3'h5, 7'h02}, 10'h000, 1'b0);
    i_ctl.cmd({3'h6, 7'h02}, 10'h000, 1'b1);
    i_ctl.idle(4);
    chk_flag(bopen, 8'h28);
  endtask
  task automatic t_seq4();
    wr(3'h3, 9'h000, 4, 32'hB0B0_0000, 4'h0);
    rd(3'h3, 9'h000);
    i_ctl.idle(2);
    rd(3'h3, 9'h002);
    i_ctl.idle(16);
    expect_seq(32'hB0B0_0000, 64'h1032_3210, 8);
  endtask
  task automatic t_mask();
    wr(3'h5, 9'h000, 4, 32'hC0C0_C0C0, 4'h0);
    wr(3'h5, 9'h000, 4, 32'hD1D2_D3D0, 4'h5);
    rd(3'h5, 9'h000);
    i_ctl.idle(14);
    chk_word(i_ctl.rd_q[1], 32'hD1C0_D3C1);
    chk_word(i_ctl.rd_q[3], 32'hD1D2_D3D3);
    i_ctl.rd_q.delete();
  endtask
  task automatic t_bl8();
    bf <= 8'h03;
    wr(3'h3, 9'h000, 8, 32'hE0E0_0000, 4'h0);
    bf <= 8'h0B;
    rd(3'h3, 9'h002);
    i_ctl.idle(18);
    expect_seq(32'hE0E0_0000, 64'h5476_1032, 8);
    bf <= 8'h03;
    rd(3'h3, 9'h002);
    i_ctl.idle(18);
    expect_seq(32'hE0E0_0000, 64'h1076_5432, 8);
    rd(3'h3, 9'h000);
    i_ctl.idle(2);
    rd(3'h3, 9'h004);
    i_ctl.idle(22);
    expect_seq(32'hE0E0_0000, 64'h3210_7654_3210, 12);
    bf <= 8'h12;
    rd(3'h3, 9'h002);
    i_ctl.idle(14);
    expect_seq(32'hE0E0_0000, 64'h5432, 4);
    bf <= 8'h0C;
    wr(3'h3, 9'h000, 16, 32'hF0F0_0000, 4'h0);
    rd(3'h3, 9'h004);
    i_ctl.idle(30);
    expect_seq(32'hF0F0_0000, 64'h3210_FEDC_BA98_7654, 16);
    bf <= 8'h22;
  endtask
  // RL4: nothing yet where RL3 would have shown two beats
  task automatic t_lat();
    lf <= 8'h02;
    rd(3'h3, 9'h000);
    i_ctl.idle(6);
    chk_word(DQ_W'(i_ctl.rd_q.size()), 32'h0);
    i_ctl.idle(10);
    expect_seq(32'hF0F0_0000, 64'h3210, 4);
    lf <= 8'h01;
  endtask
  task automatic t_train(input logic s, input logic [3:0] pat);
    preq <= 1'b1;
    psel <= s;
    @(posedge sys_clk_in);
    preq <= 1'b0;
    i_ctl.idle(16);
    chk_word(DQ_W'(i_ctl.rd_q.size()), 32'h4);
    for (int k = 0; k < 4; k++) chk_word(i_ctl.rd_q[k], {DQ_W{pat[k]}});
    i_ctl.rd_q.delete();
  endtask
  task automatic t_pre();
    i_ctl.cmd({3'h3, 2'b00, 1'b0, 4'hB}, 10'h000, 1'b0);
    i_ctl.idle(4);
    chk_flag(bopen, 8'h20);
    i_ctl.cmd({3'h0, 2'b00, 1'b1, 4'hB}, 10'h000, 1'b0);
    i_ctl.idle(4);
    chk_flag(bopen, 8'h00);
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk_in);
    err_total++;
    give_verdict();
  end
  initial begin
    sys_clk_in = 1'b0;
    rst_n_in   = 1'b0;
    bf         = 8'h22;
    lf         = 8'h01;
    preq       = 1'b0;
    psel       = 1'b0;
    repeat (12) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    chk_flag({5'h0, wrdy, dq_oe, dqs_oe}, 8'h04);
    chk_flag(bopen, 8'h00);
    t_banks();
    t_seq4();
    t_mask();
    t_bl8();
    t_lat();
    t_train(1'b0, 4'h5);
    t_train(1'b1, 4'hC);
    t_pre();
    give_verdict();
  end
endmodule
